// File: design/chp_pkg.sv
// Summary of operation
// - Undercurrent enable gates timeout and fall protection
// - Level bit picks 300/150 or 500/250 mA
// - Input overcurrent limit from mode base plus code
// - Bus error filters: 100ns/100us high, 10us/1ms low
// - Blanking after soft start is 100ms times 2^code
// - Fall filter 10us, 8ms, 64ms or 256ms
// - Battery overvoltage 4V plus 25mV steps, saturating
// - One bit selects 2 or 5 milliohm sense
// - Battery overcurrent 3A plus 100mA steps
// - Regulation lasting 650ms stops charging unless disabled
// - Current regulation lengthens battery overcurrent filter 500us
// - Current regulation margin 200 to 500mA
// - Voltage regulation lengthens battery overvoltage filter 500us
// - Voltage regulation margin 50 to 200mV
// - Output overvoltage 4.6V plus 200mV steps
// - Output overvoltage filter 100us or 1ms
// - Each protection inactive while its enable is 0
// - Flag events set flags, unmasked ones pull interrupt
// - Condition flags survive reads while condition persists
// - Event flags clear on any read
// - Masked flags still set, no interrupt; masks reset 0
// - Read returns value, then clears
package chp_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_INPUT_CURRENT_LIMITS      = 8'h07;
	localparam logic [7:0] ADDR_BUS_DEGLITCH_TIMING       = 8'h08;
	localparam logic [7:0] ADDR_BATTERY_OVERVOLTAGE_CONFIG = 8'h09;
	localparam logic [7:0] ADDR_BATTERY_OVERCURRENT_CONFIG = 8'h0a;
	localparam logic [7:0] ADDR_REGULATION_CONFIG         = 8'h0b;
	localparam logic [7:0] ADDR_OUTPUT_OVERVOLTAGE_CONFIG = 8'h0c;
	localparam logic [7:0] ADDR_FAULT_FLAGS_FIRST         = 8'h0d;
	localparam logic [7:0] ADDR_FAULT_MASKS_FIRST         = 8'h0e;
	// Reset values
	localparam logic [7:0] RST_INPUT_CURRENT_LIMITS = 8'hb9;
	localparam logic [7:0] RST_BUS_DEGLITCH_TIMING  = 8'h06;
	localparam logic [7:0] RST_BATTERY_OV           = 8'h8e;
	localparam logic [7:0] RST_BATTERY_OC           = 8'hb4;
	localparam logic [7:0] RST_REGULATION           = 8'h24;
	localparam logic [7:0] RST_OUTPUT_OV            = 8'h0b;
	localparam logic [7:0] RST_FLAGS                = 8'h00;
	localparam logic [7:0] RST_MASKS                = 8'h00;
	// Writable bits; reserved bits read zero
	localparam logic [7:0] WM_BUS_DEGLITCH = 8'h3f;
	localparam logic [7:0] WM_BATTERY_OV   = 8'hbf;
	localparam logic [7:0] WM_REGULATION   = 8'h7f;
	localparam logic [7:0] WM_OUTPUT_OV    = 8'h0f;
	// Flags cleared by a read only once their condition is gone
	localparam logic [7:0] COND_HELD_FLAGS = 8'he8;
	// Register layouts
	typedef struct packed {
		logic       input_undercurrent_enable;
		logic       input_undercurrent_level;
		logic       input_overcurrent_enable;
		logic [4:0] input_overcurrent_limit;
	} chp_icl_t;
	typedef struct packed {
		logic [1:0] rsvd;
		logic       bus_high_error_filter;
		logic       bus_low_error_filter;
		logic [1:0] undercurrent_blanking_code;
		logic [1:0] undercurrent_fall_filter;
	} chp_bdt_t;
	typedef struct packed {
		logic       battery_overvoltage_enable;
		logic       rsvd;
		logic [5:0] battery_overvoltage_level;
	} chp_bov_t;
	typedef struct packed {
		logic       battery_overcurrent_enable;
		logic       sense_resistor_select;
		logic [5:0] battery_overcurrent_limit;
	} chp_boc_t;
	typedef struct packed {
		logic       rsvd;
		logic       regulation_timeout_off;
		logic       battery_current_regulation_on;
		logic [1:0] battery_current_margin;
		logic       battery_voltage_regulation_on;
		logic [1:0] battery_voltage_margin;
	} chp_reg_t;
	typedef struct packed {
		logic [3:0] rsvd;
		logic       output_overvoltage_enable;
		logic [1:0] output_overvoltage_level;
		logic       output_overvoltage_filter;
	} chp_oov_t;
	// Comparator and status levels from the analog side
	typedef struct packed {
		logic bus_high;
		logic bus_low;
		logic ucp_below_fall;
		logic ucp_above_rise;
		logic ibus_over;
		logic vbat_over;
		logic ibat_over;
		logic vout_over;
		logic regulating;
		logic soft_start_done;
		logic switching_on;
		logic divider_mode;
		logic adapter_over;
		logic adapter_pulldown;
		logic bus_pulldown;
		logic drop_over;
		logic bus_over;
	} chp_sense_t;
	// Protection actions, levels
	typedef struct packed {
		logic bus_high;
		logic bus_low;
		logic ucp_fall;
		logic ucp_timeout;
		logic ibus_over;
		logic vbat_over;
		logic ibat_over;
		logic vout_over;
		logic reg_timeout;
	} chp_trip_t;
	typedef struct packed {
		logic [15:0] ucp_rise_ma;
		logic [15:0] ucp_fall_ma;
		logic [15:0] input_overcurrent_limit_ma;
		logic [15:0] vbat_ovp_mv;
		logic [15:0] battery_overcurrent_config_ma;
		logic [15:0] battery_current_margin_ma;
		logic [15:0] vbat_reg_mv;
		logic [15:0] output_overvoltage_config_mv;
		logic        sense_5mohm;
	} chp_limits_t;
	// Threshold arithmetic
	localparam logic [15:0] UCP_RISE_LO = 16'd300;
	localparam logic [15:0] UCP_FALL_LO = 16'd150;
	localparam logic [15:0] UCP_RISE_HI = 16'd500;
	localparam logic [15:0] UCP_FALL_HI = 16'd250;
	localparam logic [15:0] IBUS_DIV_BASE = 16'd1500;
	localparam logic [15:0] IBUS_BYP_BASE = 16'd2500;
	localparam logic [15:0] STEP_100      = 16'd100;
	localparam logic [15:0] VBAT_BASE     = 16'd4000;
	localparam logic [15:0] VBAT_STEP     = 16'd25;
	localparam logic [5:0]  VBAT_SAT_CODE = 6'h28;
	localparam logic [15:0] IBAT_BASE     = 16'd3000;
	localparam logic [15:0] IREG_BASE     = 16'd200;
	localparam logic [15:0] VREG_BASE     = 16'd50;
	localparam logic [15:0] VREG_STEP     = 16'd50;
	localparam logic [15:0] VOUT_BASE     = 16'd4600;
	localparam logic [15:0] VOUT_STEP     = 16'd200;
	// Timing, figures in their own units
	localparam int CLK_KHZ        = 125000;
	localparam int T_HI_SHORT_NS  = 100;
	localparam int T_HI_LONG_US   = 100;
	localparam int T_LO_SHORT_US  = 10;
	localparam int T_LO_LONG_MS   = 1;
	localparam int T_BLK_BASE_MS  = 100;
	localparam int T_FALL0_US     = 10;
	localparam int T_FALL1_MS     = 8;
	localparam int T_FALL2_MS     = 64;
	localparam int T_FALL3_MS     = 256;
	localparam int T_REG_TO_MS    = 650;
	localparam int T_REG_DEG_US   = 500;
	localparam int T_OOV_SHORT_US = 100;
	localparam int T_OOV_LONG_MS  = 1;
	localparam int T_BASE_DEG_NS  = 100;
	localparam int CYC_HI_SHORT  = (T_HI_SHORT_NS * CLK_KHZ + 999999) / 1000000;
	localparam int CYC_LO_SHORT  = T_LO_SHORT_US * CLK_KHZ / 1000;
	localparam int CYC_FALL0     = T_FALL0_US * CLK_KHZ / 1000;
	localparam int CYC_BASE_DEG  = (T_BASE_DEG_NS * CLK_KHZ + 999999) / 1000000;
	localparam int CYC_HI_LONG   = T_HI_LONG_US * CLK_KHZ / 1000;
	localparam int CYC_LO_LONG   = T_LO_LONG_MS * CLK_KHZ;
	localparam int CYC_BLK_BASE  = T_BLK_BASE_MS * CLK_KHZ;
	localparam int CYC_FALL1     = T_FALL1_MS * CLK_KHZ;
	localparam int CYC_FALL2     = T_FALL2_MS * CLK_KHZ;
	localparam int CYC_FALL3     = T_FALL3_MS * CLK_KHZ;
	localparam int CYC_REG_TO    = T_REG_TO_MS * CLK_KHZ;
	localparam int CYC_REG_DEG   = T_REG_DEG_US * CLK_KHZ / 1000;
	localparam int CYC_OOV_SHORT = T_OOV_SHORT_US * CLK_KHZ / 1000;
	localparam int CYC_OOV_LONG  = T_OOV_LONG_MS * CLK_KHZ;
	localparam int CNT_W         = 27;
endpackage : chp_pkg

// File: design/chp_protection_regs.sv
`timescale 1ns/1ps
`default_nettype none

module chp_deglitch #(
	parameter int CW = 27
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          cond,
	input  wire logic [CW-1:0] limit,
	output var  logic          held
);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (!cond) begin
			nxt_cnt = '0;
		end else if (cnt_ff < limit) begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			held   <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			// A limit shortened mid-count still trips instead of wrapping
			held   <= cond && (nxt_cnt >= limit);
		end
	end
endmodule : chp_deglitch

module chp_protection_regs #(
	parameter int P_CYC_HI_LONG   = chp_pkg::CYC_HI_LONG,
	parameter int P_CYC_LO_LONG   = chp_pkg::CYC_LO_LONG,
	parameter int P_CYC_BLK_BASE  = chp_pkg::CYC_BLK_BASE,
	parameter int P_CYC_FALL1     = chp_pkg::CYC_FALL1,
	parameter int P_CYC_FALL2     = chp_pkg::CYC_FALL2,
	parameter int P_CYC_FALL3     = chp_pkg::CYC_FALL3,
	parameter int P_CYC_REG_TO    = chp_pkg::CYC_REG_TO,
	parameter int P_CYC_REG_DEG   = chp_pkg::CYC_REG_DEG,
	parameter int P_CYC_OOV_SHORT = chp_pkg::CYC_OOV_SHORT,
	parameter int P_CYC_OOV_LONG  = chp_pkg::CYC_OOV_LONG
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Register port behind the serial target
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_wr_en,
	input  wire logic                 reg_rd_en,
	input  wire logic [7:0]           reg_wdata,
	output var  logic [7:0]           reg_rdata,
	output var  logic                 reg_rd_valid,
	// Analog comparators and power stage status
	input  wire chp_pkg::chp_sense_t  sense_async,
	// Protection actions and thresholds
	output var  chp_pkg::chp_trip_t   trip,
	output var  chp_pkg::chp_limits_t limits,
	// Interrupt pin
	output var  logic                 interrupt_out_n
);
	localparam int CW = chp_pkg::CNT_W;

	if (P_CYC_BLK_BASE * 8 >= (1 << CW) || P_CYC_REG_TO >= (1 << CW) ||
	    P_CYC_FALL3 >= (1 << CW) || P_CYC_HI_LONG < 1) begin : g_bad_count
		$error("chp_protection_regs: count does not fit the timer width");
	end

	chp_pkg::chp_icl_t  icl_ff;
	chp_pkg::chp_bdt_t  bdt_ff;
	chp_pkg::chp_bov_t  bov_ff;
	chp_pkg::chp_boc_t  boc_ff;
	chp_pkg::chp_reg_t  rgl_ff;
	chp_pkg::chp_oov_t  oov_ff;
	logic [7:0]         flags_ff;
	logic [7:0]         masks_ff;
	chp_pkg::chp_sense_t s1_ff, s2_ff, s3_ff, sf_ff;

	// Three-stage capture, a change counts once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			sf_ff <= '0;
		end else begin
			s1_ff <= sense_async;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			sf_ff <= (s2_ff & s3_ff) | (sf_ff & (s2_ff | s3_ff));
		end
	end

	// Register writes
	wire wr_icl = reg_wr_en && reg_addr == chp_pkg::ADDR_INPUT_CURRENT_LIMITS;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			icl_ff   <= chp_pkg::RST_INPUT_CURRENT_LIMITS;
			bdt_ff   <= chp_pkg::RST_BUS_DEGLITCH_TIMING;
			bov_ff   <= chp_pkg::RST_BATTERY_OV;
			boc_ff   <= chp_pkg::RST_BATTERY_OC;
			rgl_ff   <= chp_pkg::RST_REGULATION;
			oov_ff   <= chp_pkg::RST_OUTPUT_OV;
			masks_ff <= chp_pkg::RST_MASKS;
		end else if (reg_wr_en) begin
			case (reg_addr)
				chp_pkg::ADDR_INPUT_CURRENT_LIMITS: begin
					// Level is frozen once switching runs
					icl_ff <= sf_ff.switching_on ?
						{reg_wdata[7], icl_ff.input_undercurrent_level, reg_wdata[5:0]} :
						reg_wdata;
				end
				chp_pkg::ADDR_BUS_DEGLITCH_TIMING: bdt_ff <= reg_wdata & chp_pkg::WM_BUS_DEGLITCH;
				chp_pkg::ADDR_BATTERY_OVERVOLTAGE_CONFIG: bov_ff <= reg_wdata & chp_pkg::WM_BATTERY_OV;
				chp_pkg::ADDR_BATTERY_OVERCURRENT_CONFIG: boc_ff <= reg_wdata;
				chp_pkg::ADDR_REGULATION_CONFIG: rgl_ff <= reg_wdata & chp_pkg::WM_REGULATION;
				chp_pkg::ADDR_OUTPUT_OVERVOLTAGE_CONFIG: oov_ff <= reg_wdata & chp_pkg::WM_OUTPUT_OV;
				chp_pkg::ADDR_FAULT_MASKS_FIRST: masks_ff <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Threshold outputs
	logic [5:0] vbat_code;
	assign vbat_code = (bov_ff.battery_overvoltage_level >= chp_pkg::VBAT_SAT_CODE) ?
		chp_pkg::VBAT_SAT_CODE : bov_ff.battery_overvoltage_level;
	chp_pkg::chp_limits_t nxt_limits;
	always_comb begin
		nxt_limits.ucp_rise_ma = icl_ff.input_undercurrent_level ?
			chp_pkg::UCP_RISE_HI : chp_pkg::UCP_RISE_LO;
		nxt_limits.ucp_fall_ma = icl_ff.input_undercurrent_level ?
			chp_pkg::UCP_FALL_HI : chp_pkg::UCP_FALL_LO;
		nxt_limits.input_overcurrent_limit_ma = (sf_ff.divider_mode ? chp_pkg::IBUS_DIV_BASE : chp_pkg::IBUS_BYP_BASE)
			+ 16'(icl_ff.input_overcurrent_limit) * chp_pkg::STEP_100;
		nxt_limits.vbat_ovp_mv = chp_pkg::VBAT_BASE + 16'(vbat_code) * chp_pkg::VBAT_STEP;
		nxt_limits.battery_overcurrent_config_ma = chp_pkg::IBAT_BASE
			+ 16'(boc_ff.battery_overcurrent_limit) * chp_pkg::STEP_100;
		nxt_limits.battery_current_margin_ma = nxt_limits.battery_overcurrent_config_ma - (chp_pkg::IREG_BASE
			+ 16'(rgl_ff.battery_current_margin) * chp_pkg::STEP_100);
		nxt_limits.vbat_reg_mv = nxt_limits.vbat_ovp_mv - (chp_pkg::VREG_BASE
			+ 16'(rgl_ff.battery_voltage_margin) * chp_pkg::VREG_STEP);
		nxt_limits.output_overvoltage_config_mv = chp_pkg::VOUT_BASE
			+ 16'(oov_ff.output_overvoltage_level) * chp_pkg::VOUT_STEP;
		nxt_limits.sense_5mohm = boc_ff.sense_resistor_select;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			limits <= '0;
		end else begin
			limits <= nxt_limits;
		end
	end

	// Filter lengths
	logic [CW-1:0] lim_hi, lim_lo, lim_fall, lim_blk, lim_bov, lim_boc, lim_oov;
	logic [CW-1:0] lim_base, lim_to;
	always_comb begin
		lim_base = CW'(chp_pkg::CYC_BASE_DEG);
		lim_to   = CW'(P_CYC_REG_TO);
		lim_hi   = bdt_ff.bus_high_error_filter ? CW'(P_CYC_HI_LONG) :
			CW'(chp_pkg::CYC_HI_SHORT);
		lim_lo   = bdt_ff.bus_low_error_filter ? CW'(P_CYC_LO_LONG) :
			CW'(chp_pkg::CYC_LO_SHORT);
		lim_blk  = CW'(P_CYC_BLK_BASE) << bdt_ff.undercurrent_blanking_code;
		case (bdt_ff.undercurrent_fall_filter)
			2'h0:    lim_fall = CW'(chp_pkg::CYC_FALL0);
			2'h1:    lim_fall = CW'(P_CYC_FALL1);
			2'h2:    lim_fall = CW'(P_CYC_FALL2);
			default: lim_fall = CW'(P_CYC_FALL3);
		endcase
		lim_bov  = rgl_ff.battery_voltage_regulation_on ? CW'(P_CYC_REG_DEG) : lim_base;
		lim_boc  = rgl_ff.battery_current_regulation_on ? CW'(P_CYC_REG_DEG) : lim_base;
		lim_oov  = oov_ff.output_overvoltage_filter ? CW'(P_CYC_OOV_LONG) :
			CW'(P_CYC_OOV_SHORT);
	end

	// Undercurrent blanking after soft start
	logic          ucp_run;
	logic          seen_rise_ff;
	logic          blank_done_ff;
	logic [CW-1:0] blk_cnt_ff;
	logic          ucp_to_ev;
	assign ucp_run   = sf_ff.switching_on && icl_ff.input_undercurrent_enable;
	assign ucp_to_ev = ucp_run && sf_ff.soft_start_done && !blank_done_ff && !seen_rise_ff
		&& !sf_ff.ucp_above_rise && blk_cnt_ff == lim_blk - 1'b1;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seen_rise_ff  <= 1'b0;
			blank_done_ff <= 1'b0;
			blk_cnt_ff    <= '0;
		end else if (!ucp_run) begin
			seen_rise_ff  <= 1'b0;
			blank_done_ff <= 1'b0;
			blk_cnt_ff    <= '0;
		end else begin
			if (sf_ff.ucp_above_rise) begin
				seen_rise_ff <= 1'b1;
			end
			if (sf_ff.soft_start_done && !blank_done_ff) begin
				if (blk_cnt_ff == lim_blk - 1'b1) begin
					blank_done_ff <= 1'b1;
				end else begin
					blk_cnt_ff <= blk_cnt_ff + 1'b1;
				end
			end
		end
	end

	// Deglitch filters: high, low, fall, ibus, vbat, ibat, vout, regulation
	logic [7:0]    dg_cond, dg_held;
	logic [CW-1:0] dg_lim [8];
	always_comb begin
		dg_cond = {sf_ff.bus_high, sf_ff.bus_low, ucp_run && seen_rise_ff && sf_ff.ucp_below_fall,
			sf_ff.ibus_over, sf_ff.vbat_over, sf_ff.ibat_over, sf_ff.vout_over,
			sf_ff.regulating && !rgl_ff.regulation_timeout_off};
		dg_lim[7] = lim_hi;
		dg_lim[6] = lim_lo;
		dg_lim[5] = lim_fall;
		dg_lim[4] = lim_base;
		dg_lim[3] = lim_bov;
		dg_lim[2] = lim_boc;
		dg_lim[1] = lim_oov;
		dg_lim[0] = lim_to;
	end
	for (genvar i = 0; i < 8; i++) begin : g_dg
		chp_deglitch #(.CW(CW)) u_dg (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.cond    (dg_cond[i]),
			.limit   (dg_lim[i]),
			.held    (dg_held[i])
		);
	end

	// Protection actions; timeout holds until switching stops or undercurrent enable clears
	chp_pkg::chp_trip_t nxt_trip;
	always_comb begin
		nxt_trip.bus_high    = dg_held[7];
		nxt_trip.bus_low     = dg_held[6];
		nxt_trip.ucp_fall    = dg_held[5] && icl_ff.input_undercurrent_enable;
		nxt_trip.ucp_timeout = (ucp_to_ev || trip.ucp_timeout) && ucp_run;
		nxt_trip.ibus_over   = dg_held[4] && icl_ff.input_overcurrent_enable;
		nxt_trip.vbat_over   = dg_held[3] && bov_ff.battery_overvoltage_enable;
		nxt_trip.ibat_over   = dg_held[2] && boc_ff.battery_overcurrent_enable;
		nxt_trip.vout_over   = dg_held[1] && oov_ff.output_overvoltage_enable;
		nxt_trip.reg_timeout = dg_held[0] && !rgl_ff.regulation_timeout_off;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trip <= '0;
		end else begin
			trip <= nxt_trip;
		end
	end

	// Fault flags; a set in the clearing cycle wins
	logic       drop_prev_ff;
	logic [7:0] flag_set, flag_clr, nxt_flags;
	logic       rd_flags;
	assign rd_flags = reg_rd_en && reg_addr == chp_pkg::ADDR_FAULT_FLAGS_FIRST;
	always_comb begin
		flag_set = {sf_ff.adapter_over, sf_ff.adapter_pulldown, sf_ff.bus_pulldown,
			sf_ff.drop_over && !drop_prev_ff, sf_ff.bus_over,
			nxt_trip.ibus_over && !trip.ibus_over,
			nxt_trip.ucp_timeout && !trip.ucp_timeout,
			nxt_trip.ucp_fall && !trip.ucp_fall};
		flag_clr = rd_flags ? ~(chp_pkg::COND_HELD_FLAGS & flag_set) : 8'h00;
		nxt_flags = (flags_ff & ~flag_clr) | flag_set;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff     <= chp_pkg::RST_FLAGS;
			drop_prev_ff <= 1'b0;
		end else begin
			flags_ff     <= nxt_flags;
			drop_prev_ff <= sf_ff.drop_over;
		end
	end

	// Interrupt pin, masked flags still latch
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_out_n <= 1'b1;
		end else begin
			interrupt_out_n <= ~|(flags_ff & ~masks_ff);
		end
	end

	// Read data; unmapped offsets answer zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata    <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				case (reg_addr)
					chp_pkg::ADDR_INPUT_CURRENT_LIMITS:       reg_rdata <= icl_ff;
					chp_pkg::ADDR_BUS_DEGLITCH_TIMING:        reg_rdata <= bdt_ff;
					chp_pkg::ADDR_BATTERY_OVERVOLTAGE_CONFIG: reg_rdata <= bov_ff;
					chp_pkg::ADDR_BATTERY_OVERCURRENT_CONFIG: reg_rdata <= boc_ff;
					chp_pkg::ADDR_REGULATION_CONFIG:          reg_rdata <= rgl_ff;
					chp_pkg::ADDR_OUTPUT_OVERVOLTAGE_CONFIG:  reg_rdata <= oov_ff;
					chp_pkg::ADDR_FAULT_FLAGS_FIRST:          reg_rdata <= flags_ff;
					chp_pkg::ADDR_FAULT_MASKS_FIRST:          reg_rdata <= masks_ff;
					default:                                  reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_flag_read;
		rd_flags;
	endsequence
	sequence s_quiet_ibus;
		!(nxt_trip.ibus_over && !trip.ibus_over);
	endsequence

	chk_irq_unmasked: assert property (|(flags_ff & ~masks_ff) |=> !interrupt_out_n)
		else $error("unmasked flag did not assert interrupt");
	chk_mask_blocks_irq: assert property ((flags_ff & ~masks_ff) == 8'h00
		|=> interrupt_out_n)
		else $error("masked flag drove interrupt");
	chk_event_clear: assert property (s_flag_read ##0 s_quiet_ibus |=> !flags_ff[2])
		else $error("event flag survived read");
	chk_cond_hold: assert property (s_flag_read ##0 sf_ff.bus_over |=> flags_ff[3])
		else $error("condition flag cleared while condition present");
	chk_read_value: assert property (s_flag_read
		|=> reg_rd_valid && reg_rdata == $past(flags_ff))
		else $error("flag read returned wrong value");
	chk_ucp_gate: assert property (!icl_ff.input_undercurrent_enable
		|=> !trip.ucp_fall && !trip.ucp_timeout)
		else $error("undercurrent action while disabled");
	chk_level_lock: assert property (wr_icl && sf_ff.switching_on
		|=> $stable(icl_ff.input_undercurrent_level))
		else $error("level changed while switching");
	chk_timeout_off: assert property (rgl_ff.regulation_timeout_off
		|=> !trip.reg_timeout)
		else $error("regulation timeout while disabled");
	chk_enable_gate: assert property (!oov_ff.output_overvoltage_enable
		|| !boc_ff.battery_overcurrent_enable
		|=> !(trip.vout_over && $past(!oov_ff.output_overvoltage_enable))
		&& !(trip.ibat_over && $past(!boc_ff.battery_overcurrent_enable)))
		else $error("protection active while disabled");
	chk_high_filter: assert property ($rose(trip.bus_high)
		&& !bdt_ff.bus_high_error_filter
		|-> $past(sf_ff.bus_high, 2) && $past(sf_ff.bus_high, 8))
		else $error("bus high action without held condition");
	chk_vbat_sat: assert property (bov_ff.battery_overvoltage_level
		>= chp_pkg::VBAT_SAT_CODE |=> limits.vbat_ovp_mv == 16'd5000)
		else $error("battery threshold not saturated");
endmodule : chp_protection_regs

`default_nettype wire

// File: tb/chp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module chp_host (
	// Clock
	input  wire logic       clk_sys,
	// Register port
	output var  logic [7:0] reg_addr,
	output var  logic       reg_wr_en,
	output var  logic       reg_rd_en,
	output var  logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rd_valid
);
	initial begin
		reg_addr  = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
	end
	// Level bit sent as given, also while switching runs
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr_en <= 1'b1;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask : wr
	// Data is taken at the edge that samples valid high
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		@(posedge clk_sys);
		d = reg_rd_valid ? reg_rdata : 8'hxx;
	endtask : rd
endmodule : chp_host

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                 clk_sys = 1'b0;
	logic                 rst_n   = 1'b0;
	logic [7:0]           reg_addr, reg_wdata, reg_rdata;
	logic                 reg_wr_en, reg_rd_en, reg_rd_valid, interrupt_out_n;
	chp_pkg::chp_sense_t  sense = 17'h00020;
	chp_pkg::chp_trip_t   trip;
	chp_pkg::chp_limits_t limits;
	int                   fails = 0;
	int                   tests_run = 0;

	always #4 clk_sys = ~clk_sys;

	// Short timers; the undercurrent scenario withholds the rise on purpose
	chp_protection_regs #(.P_CYC_HI_LONG(20), .P_CYC_LO_LONG(25), .P_CYC_BLK_BASE(20),
		.P_CYC_FALL1(30), .P_CYC_FALL2(40), .P_CYC_FALL3(50), .P_CYC_REG_TO(60),
		.P_CYC_REG_DEG(25), .P_CYC_OOV_SHORT(15), .P_CYC_OOV_LONG(35))
		chp_protection_regs_i (.clk_sys, .rst_n, .reg_addr, .reg_wr_en,
		.reg_rd_en, .reg_wdata, .reg_rdata, .reg_rd_valid, .sense_async(sense), .trip,
		.limits, .interrupt_out_n);
	chp_host chp_host_i (.clk_sys, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
		.reg_rdata, .reg_rd_valid);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		chp_host_i.rd(a, d);
		chk("reg", {8'h00, e}, {8'h00, d});
	endtask : rc
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : w
	task automatic t_reset();
		rc(8'h07, 8'hb9);
		rc(8'h08, 8'h06);
		rc(8'h09, 8'h8e);
		rc(8'h0a, 8'hb4);
		rc(8'h0b, 8'h24);
		rc(8'h0c, 8'h0b);
		rc(8'h0d, 8'h00);
		rc(8'h0e, 8'h00);
		rc(8'h0f, 8'h00);
		$display("reset values done");
	endtask : t_reset
	task automatic t_limits();
		chk("ucp_rise", 16'd300, limits.ucp_rise_ma);
		chk("ucp_fall", 16'd150, limits.ucp_fall_ma);
		chk("input_overcurrent_limit", 16'd4000, limits.input_overcurrent_limit_ma);
		chk("vbat_ovp", 16'd4350, limits.vbat_ovp_mv);
		chk("battery_overcurrent_config", 16'd8200, limits.battery_overcurrent_config_ma);
		chk("output_overvoltage_config", 16'd4800, limits.output_overvoltage_config_mv);
		chk("battery_current_margin", 16'd8000, limits.battery_current_margin_ma);
		chk("vbat_reg", 16'd4300, limits.vbat_reg_mv);
		chp_host_i.wr(8'h07, 8'hff);
		chp_host_i.wr(8'h09, 8'hff);
		chp_host_i.wr(8'h0a, 8'h7f);
		chp_host_i.wr(8'h0c, 8'hff);
		chp_host_i.wr(8'h0d, 8'hff);
		sense.divider_mode <= 1'b0;
		w(8);
		chk("ucp_rise", 16'd500, limits.ucp_rise_ma);
		chk("ucp_fall", 16'd250, limits.ucp_fall_ma);
		chk("input_overcurrent_limit", 16'd5600, limits.input_overcurrent_limit_ma);
		chk("vbat_ovp", 16'd5000, limits.vbat_ovp_mv);
		chk("battery_overcurrent_config", 16'd9300, limits.battery_overcurrent_config_ma);
		chk("sense", 16'd1, {15'd0, limits.sense_5mohm});
		chk("output_overvoltage_config", 16'd5200, limits.output_overvoltage_config_mv);
		chk("battery_current_margin", 16'd9100, limits.battery_current_margin_ma);
		chk("vbat_reg", 16'd4950, limits.vbat_reg_mv);
		rc(8'h09, 8'hbf);
		rc(8'h0c, 8'h0f);
		rc(8'h0d, 8'h00);
		$display("limits done");
	endtask : t_limits
	task automatic t_flags();
		sense.bus_over <= 1'b1;
		w(8);
		chk("int_n", 16'd0, {15'd0, interrupt_out_n});
		rc(8'h0d, 8'h08);
		rc(8'h0d, 8'h08);
		sense.bus_over <= 1'b0;
		w(8);
		rc(8'h0d, 8'h08);
		rc(8'h0d, 8'h00);
		chk("int_n", 16'd1, {15'd0, interrupt_out_n});
		chp_host_i.wr(8'h0e, 8'h10);
		sense.drop_over <= 1'b1;
		w(8);
		sense.drop_over <= 1'b0;
		w(4);
		chk("int_n", 16'd1, {15'd0, interrupt_out_n});
		rc(8'h0d, 8'h10);
		rc(8'h0d, 8'h00);
		$display("flags done");
	endtask : t_flags
	task automatic t_ocp();
		chp_host_i.wr(8'h07, 8'hd9);
		sense.ibus_over <= 1'b1;
		w(30);
		chk("trip", 16'd0, {15'd0, trip.ibus_over});
		rc(8'h0d, 8'h00);
		chp_host_i.wr(8'h07, 8'hf9);
		w(30);
		chk("trip", 16'd1, {15'd0, trip.ibus_over});
		rc(8'h0d, 8'h04);
		rc(8'h0d, 8'h00);
		sense.ibus_over <= 1'b0;
		$display("overcurrent done");
	endtask : t_ocp
	task automatic t_trips();
		w(1);
		sense <= 17'h000e0;
		w(8);
		chp_host_i.wr(8'h07, 8'h19);
		rc(8'h07, 8'h59);
		chk("ucp_to", 16'd0, {15'd0, trip.ucp_timeout});
		chp_host_i.wr(8'h07, 8'hd9);
		w(30);
		chk("ucp_to", 16'd0, {15'd0, trip.ucp_timeout});
		w(20);
		chk("ucp_to", 16'd1, {15'd0, trip.ucp_timeout});
		chk("int_n", 16'd0, {15'd0, interrupt_out_n});
		rc(8'h0d, 8'h02);
		rc(8'h0d, 8'h00);
		// Bus high, battery, output and regulation up; switching off
		sense <= 17'h10f20;
		w(24);
		chk("bus_high", 16'd1, {15'd0, trip.bus_high});
		chk("vbat_ov", 16'd0, {15'd0, trip.vbat_over});
		w(20);
		chk("vbat_ov", 16'd1, {15'd0, trip.vbat_over});
		chk("vout_ov", 16'd1, {15'd0, trip.vout_over});
		chk("ibat_ov", 16'd0, {15'd0, trip.ibat_over});
		chk("reg_to", 16'd0, {15'd0, trip.reg_timeout});
		w(30);
		chk("reg_to", 16'd1, {15'd0, trip.reg_timeout});
		chp_host_i.wr(8'h0b, 8'h64);
		w(2);
		chk("reg_to", 16'd0, {15'd0, trip.reg_timeout});
		sense <= 17'h00020;
		w(10);
		chk("bus_high", 16'd0, {15'd0, trip.bus_high});
		$display("trips done");
	endtask : t_trips
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	initial begin
		w(20000);
		fails++;
		summarize();
	end
	initial begin
		w(16);
		rst_n <= 1'b1;
		w(4);
		t_reset();
		t_limits();
		t_flags();
		t_ocp();
		t_trips();
		summarize();
	end
endmodule : testbench

`default_nettype wire
